// ===== logic/irag_gain_ctrl.sv
// gain-step controller for the infrared receive amplifier
`timescale 1ns/100ps
module irag_gain_ctrl #(
   parameter int SILENCE = irag_pkg::SILENCE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // host pins
   input wire logic transmitData,
   input wire logic gainReset,
   input wire logic sense_select,
   // measurement path: detected pulse or burst and its verdict
   input wire irag_pkg::irag_event_t rxEvent,
   input wire logic rxPulse,
   // to the analog side and the host
   output irag_pkg::irag_gain_t gain_stage,
   output logic emitter_drive,
   output logic rxOut
);
   logic [irag_pkg::ATTEN_W-1:0] atten; // present attenuation steps
   logic frozen; // no gain step allowed
   logic lowerReq; // strength says too strong
   logic raiseReq; // strength weak or silence step
   logic silenceStep; // interval of silence elapsed

   // freeze while sending or held at maximum sensitivity
   assign frozen = transmitData || gainReset;

   // three-way decision on each detected event unless frozen
   always_comb
   begin
      lowerReq = 1'b0;
      raiseReq = silenceStep;
      if (rxEvent.detect && !frozen)
      begin
         case (rxEvent.action)
            irag_pkg::IRAG_LOWER: lowerReq = 1'b1;
            irag_pkg::IRAG_RAISE: raiseReq = 1'b1;
            irag_pkg::IRAG_KEEP: lowerReq = 1'b0;
            default: lowerReq = 1'b0;
         endcase
      end
   end

   // silence timer, restarted by any detected input
   irag_silence_timer #(.COUNT(SILENCE)) timer (
      .clk(clk),
      .reset_n(reset_n),
      .restart(rxEvent.detect),
      .hold(frozen),
      .expire(silenceStep)
   );

   // attenuation counter: lower gain means more attenuation
   irag_atten_counter #(.STEPS(irag_pkg::ATTEN_STEPS)) counter (
      .clk(clk),
      .reset_n(reset_n),
      .force_max(gainReset),
      .up(lowerReq),
      .down(raiseReq),
      .atten(atten)
   );

   // registered gain word to the amplifier
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gain_stage.baseGain <= irag_pkg::BASE_GAIN_HIGH;
         gain_stage.atten <= irag_pkg::ATTEN_RESET;
      end
      else
      begin
         gain_stage.baseGain <= sense_select ? irag_pkg::BASE_GAIN_HIGH
                                             : irag_pkg::BASE_GAIN_LOW;
         gain_stage.atten <= atten;
      end
   end

   // emitter follows transmit input, one register stage
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         emitter_drive <= 1'b0;
      else
         emitter_drive <= transmitData;
   end

   // receiver output passed raw; spurious pulses are the host's to filter
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rxOut <= 1'b0;
      else
         rxOut <= rxPulse;
   end

   emitter_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      transmitData |=> emitter_drive) else $error("emitter not on");
   tx_freeze_a: assert property (@(posedge clk) disable iff (!reset_n)
      transmitData && $past(transmitData) |=> $stable(gain_stage.atten))
      else $error("gain moved while sending");
   reset_max_a: assert property (@(posedge clk) disable iff (!reset_n)
      gainReset ##2 1 |-> gain_stage.atten == '0) else $error("reset not max");
   base_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      1 |=> gain_stage.baseGain == ($past(sense_select) ? 5'h11 : 5'h08))
      else $error("wrong base gain");
   lower_step_a: assert property (@(posedge clk) disable iff (!reset_n)
      lowerReq && atten < 4'hf |=> atten == $past(atten) + 4'h1)
      else $error("no lower step");
   power_on_a: assert property (@(posedge clk)
      !reset_n |=> atten == '0) else $error("power-on not max");

   // checker-only count of quiet cycles, cleared like the timer so the
   // step spacing can be judged without trusting the timer's own count
   logic [31:0] quietCycles; // cycles since last detect or freeze

   // quiet cycle counter; 32 bits never wraps within any sane run
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         quietCycles <= 32'h0;
      else if (rxEvent.detect || frozen)
         quietCycles <= 32'h0;
      else
         quietCycles <= quietCycles + 32'h1;
   end

   silence_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
      silenceStep |-> (quietCycles % 32'(SILENCE)) == 32'(SILENCE - 1))
      else $error("silence step off its interval");
   silence_due_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!rxEvent.detect && !frozen && (quietCycles % 32'(SILENCE)) == 32'(SILENCE - 1))
      |-> silenceStep) else $error("silence step missing");
   silence_raise_a: assert property (@(posedge clk) disable iff (!reset_n)
      (silenceStep && !lowerReq && atten != '0) |=> atten == $past(atten) - 4'h1)
      else $error("silence step not applied");
   send_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (transmitData && !gainReset) |=> $stable(atten)) else $error("gain moved on send");
   idle_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!rxEvent.detect && !silenceStep && !gainReset) |=> $stable(atten))
      else $error("gain moved without event");
   reset_block_a: assert property (@(posedge clk) disable iff (!reset_n)
      gainReset |=> atten == '0) else $error("pulse moved gain in reset");
endmodule

// ===== common/irag_pkg.sv
// package of constants and types for the infrared receiver gain-step controller
package irag_pkg;
   // attenuation range and step size in dB
   localparam int ATTEN_RANGE_DB = 30;
   localparam int ATTEN_STEP_DB = 2;
   // number of attenuation steps, 15
   localparam int ATTEN_STEPS = ATTEN_RANGE_DB / ATTEN_STEP_DB;
   localparam int ATTEN_W = 4;
   // reset value: no attenuation means maximum sensitivity
   localparam logic [3:0] ATTEN_RESET = 4'h0;
   localparam logic [3:0] ATTEN_MAX = 4'(ATTEN_STEPS);
   // base gain figures of the amplifier
   localparam logic [4:0] BASE_GAIN_HIGH = 5'h11;
   localparam logic [4:0] BASE_GAIN_LOW = 5'h08;
   // clock and silence time
   localparam int CLK_HZ = 10_000_000;
   localparam int SILENCE_MS = 18;
   // longest time rounds down: 180000 cycles
   localparam int SILENCE_CYCLES = (CLK_HZ / 1000) * SILENCE_MS;
   // strength decision from the measurement path
   typedef enum logic [1:0] {
      IRAG_KEEP = 2'b00,
      IRAG_LOWER = 2'b01,
      IRAG_RAISE = 2'b10
   } irag_action_t;
   // one detected input event with its verdict
   typedef struct packed {
      logic detect;
      irag_action_t action;
   } irag_event_t;
   // gain word to the analog amplifier
   typedef struct packed {
      logic [4:0] baseGain;
      logic [3:0] atten;
   } irag_gain_t;
endpackage

// ===== logic/irag_silence_timer.sv
// silence timer producing one step pulse per elapsed interval
`timescale 1ns/100ps
module irag_silence_timer #(
   parameter int COUNT = irag_pkg::SILENCE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // control
   input wire logic restart,
   input wire logic hold,
   // one-cycle step request
   output logic expire
);
   localparam int CW = $clog2(COUNT + 1);
   logic [CW-1:0] count; // cycles of silence so far in this interval

   // free counter that wraps at each interval; restart wins over counting
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         count <= '0;
      else if (restart || hold)
         count <= '0;
      else if (count == CW'(COUNT - 1))
         count <= '0;
      else
         count <= count + 1'b1;
   end

   // pulse on the last cycle of every interval
   assign expire = !restart && !hold && (count == CW'(COUNT - 1));

   interval_len_a: assert property (@(posedge clk) disable iff (!reset_n)
      expire |-> $past(count) == CW'(COUNT - 2)) else $error("step pulse early");
endmodule

// ===== logic/irag_atten_counter.sv
// saturating attenuation step counter
`timescale 1ns/100ps
module irag_atten_counter #(
   parameter int STEPS = irag_pkg::ATTEN_STEPS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // controls, force has top priority
   input wire logic force_max,
   input wire logic up,
   input wire logic down,
   // present attenuation in steps
   output logic [irag_pkg::ATTEN_W-1:0] atten
);
   // up adds attenuation (less gain), down removes it
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         atten <= irag_pkg::ATTEN_RESET;
      else if (force_max)
         atten <= irag_pkg::ATTEN_RESET;
      else if (up && atten != irag_pkg::ATTEN_W'(STEPS))
         atten <= atten + 1'b1;
      else if (down && !up && atten != '0)
         atten <= atten - 1'b1;
   end

   range_held_a: assert property (@(posedge clk) disable iff (!reset_n)
      atten <= irag_pkg::ATTEN_W'(STEPS)) else $error("attenuation out of range");
   floor_held_a: assert property (@(posedge clk) disable iff (!reset_n)
      ($past(atten) == '0 && !$past(up)) |-> atten == '0) else $error("attenuation below zero");
endmodule

// ===== testbench/irag_host_model.sv
// host model that drives the device pins and screens received pulses
`timescale 1ns/100ps
module irag_host_model (
   // clock and receiver output
   input wire logic clk,
   input wire logic rxOut,
   // pins toward the device, idle levels from time zero
   output logic transmitData = 1'b0,
   output logic gainReset = 1'b0,
   output logic sense_select = 1'b1,
   output irag_pkg::irag_event_t rxEvent = '0,
   output logic rxPulse = 1'b0,
   // received pulses kept after screening
   output logic rxClean = 1'b0
);
   logic rxLast = 1'b0; // previous receiver level
   // high sensitivity: a lone one-cycle pulse is dropped as noise
   always @(posedge clk)
   begin
      rxLast <= rxOut;
      rxClean <= rxOut & (rxLast | ~sense_select);
   end
   // level pins change just after an edge
   task pins(input logic tx, input logic gr, input logic ss);
      @(posedge clk);
      transmitData <= tx;
      gainReset <= gr;
      sense_select <= ss;
   endtask
   // n back-to-back detected events, then the detect line drops
   task events(input irag_pkg::irag_action_t a, input int n);
      repeat (n)
      begin
         @(posedge clk);
         rxEvent <= '{detect: 1'b1, action: a};
         rxPulse <= ~rxPulse;
      end
      @(posedge clk);
      rxEvent <= '0;
   endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the gain-step controller
`timescale 1ns/100ps
module tb_top;
   localparam int SIL = 20; // shortened silence interval in cycles
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic transmitData, gainReset, sense_select, rxPulse, emitter_drive, rxOut;
   irag_pkg::irag_event_t rxEvent;
   irag_pkg::irag_gain_t gain_stage;
   int error_cnt = 0;
   int checks_done = 0;
   always #50 clk = ~clk;
   irag_gain_ctrl #(.SILENCE(SIL)) irag_gain_ctrl_inst (.clk(clk), .reset_n(reset_n),
      .transmitData(transmitData), .gainReset(gainReset), .sense_select(sense_select),
      .rxEvent(rxEvent), .rxPulse(rxPulse), .gain_stage(gain_stage),
      .emitter_drive(emitter_drive), .rxOut(rxOut));
   irag_host_model irag_host_model_inst (.clk(clk), .rxOut(rxOut),
      .transmitData(transmitData), .gainReset(gainReset), .sense_select(sense_select),
      .rxEvent(rxEvent), .rxPulse(rxPulse), .rxClean());
   task check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // attenuation compare after waiting n edges
   task att(input int n, input logic [3:0] exp);
      repeat (n - 1) @(posedge clk);
      @(negedge clk);
      check("atten", {5'h00, gain_stage.atten}, {5'h00, exp});
      @(posedge clk);
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task t_power;
      @(posedge clk);
      @(negedge clk);
      check("atten", {5'h00, gain_stage.atten}, 9'h000);
      check("base", {4'h0, gain_stage.baseGain}, {4'h0, irag_pkg::BASE_GAIN_HIGH});
      @(posedge clk);
      irag_host_model_inst.pins(1'b0, 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("base", {4'h0, gain_stage.baseGain}, {4'h0, irag_pkg::BASE_GAIN_LOW});
      @(posedge clk);
      irag_host_model_inst.pins(1'b0, 1'b0, 1'b1);
      $display("power-on test done");
   endtask
   // saturate, keep, then silence steps and a raise verdict
   task t_steps;
      irag_host_model_inst.events(irag_pkg::IRAG_LOWER, 16);
      att(2, 4'h0f);
      irag_host_model_inst.events(irag_pkg::IRAG_KEEP, 3);
      @(negedge clk);
      check("rxOut", {8'h00, rxOut}, 9'h001);
      att(SIL - 4, 4'h0f);
      att(8, 4'h0e);
      att(SIL, 4'h0d);
      irag_host_model_inst.events(irag_pkg::IRAG_RAISE, 1);
      att(2, 4'h0c);
      irag_host_model_inst.events(irag_pkg::IRAG_KEEP, 2);
      att(2, 4'h0c);
      $display("step test done");
   endtask
   task t_transmit;
      irag_host_model_inst.pins(1'b1, 1'b0, 1'b1);
      @(posedge clk);
      @(negedge clk);
      check("emitter", {8'h00, emitter_drive}, 9'h001);
      @(posedge clk);
      irag_host_model_inst.events(irag_pkg::IRAG_LOWER, 3);
      att(SIL + 5, 4'h0c);
      irag_host_model_inst.pins(1'b0, 1'b0, 1'b1);
      @(posedge clk);
      @(negedge clk);
      check("emitter", {8'h00, emitter_drive}, 9'h000);
      @(posedge clk);
      $display("transmit test done");
   endtask
   task t_gain_reset;
      irag_host_model_inst.events(irag_pkg::IRAG_LOWER, 2);
      irag_host_model_inst.pins(1'b0, 1'b1, 1'b1);
      att(3, 4'h0);
      irag_host_model_inst.events(irag_pkg::IRAG_LOWER, 2);
      att(2, 4'h0);
      irag_host_model_inst.pins(1'b0, 1'b0, 1'b1);
      $display("gain reset test done");
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      t_power;
      t_steps;
      t_transmit;
      t_gain_reset;
      results;
   end
   // watchdog well past the roughly 150 cycles the tests need
   initial
   begin
      repeat (2000) @(posedge clk);
      error_cnt++;
      results;
   end
endmodule
